//--- hw/dre_pkg.sv
// Purpose: Shared constants for the descriptor RAM emulation block
// Assumes: 32-bit register port, byte addressed, one word per register
// Notes:   Descriptor slots are numbered in their layout order in RAM
package dre_pkg;
  localparam int unsigned RAM_BYTES = 512;
  localparam int unsigned RAM_WORDS = RAM_BYTES / 4;
  localparam int unsigned RAM_AW    = 7;
  localparam int unsigned NUM_DESC  = 10;
  localparam int unsigned NUM_PINS  = 11;

  localparam logic [7:0] OFS_HW_SETUP  = 8'h00;
  localparam logic [7:0] OFS_ID_LOWER  = 8'h04;
  localparam logic [7:0] OFS_ID_UPPER  = 8'h08;
  localparam logic [7:0] OFS_IND_SETUP = 8'h0c;
  localparam logic [7:0] OFS_PIN_WAKE  = 8'h10;
  localparam logic [7:0] OFS_HS_LEN    = 8'h14;
  localparam logic [7:0] OFS_FS_LEN    = 8'h18;
  localparam logic [7:0] OFS_TEXT0     = 8'h1c;
  localparam logic [7:0] OFS_TEXT1     = 8'h20;
  localparam logic [7:0] OFS_FLAGS     = 8'h24;
  localparam logic [7:0] OFS_DP_ADDR   = 8'h28;
  localparam logic [7:0] OFS_DP_DATA   = 8'h2c;
  localparam logic [7:0] OFS_STATUS    = 8'h30;

  localparam int unsigned HW_EMU_BIT   = 0;
  localparam int unsigned HW_PROT_BIT  = 1;
  localparam int unsigned HW_TEST_BIT  = 2;
  localparam int unsigned HW_GAIN_LSB  = 4;
  localparam int unsigned FLG_PWR_BIT  = 0;
  localparam int unsigned FLG_RWK_BIT  = 1;
  localparam int unsigned FLG_PME_LSB  = 2;
  localparam int unsigned BMA_PWR_BIT  = 6;
  localparam int unsigned BMA_RWK_BIT  = 5;
  localparam logic [9:0]  BMA_OFFSET   = 10'h007;

  localparam logic [7:0]  DEV_SIZE     = 8'h12;
  localparam logic [7:0]  DEV_TYPE     = 8'h01;
  localparam logic [7:0]  CFG_TYPE     = 8'h02;
  localparam logic [7:0]  EEP_FREE_LO  = 8'h96;
  localparam logic [31:0] RST_WORD     = 32'h0000_0000;

  typedef enum logic [3:0] {
    DRE_LANG = 4'h0, DRE_STR1 = 4'h1, DRE_STR2 = 4'h2, DRE_STR3 = 4'h3,
    DRE_STR4 = 4'h4, DRE_STR5 = 4'h5, DRE_HS_DEV = 4'h6, DRE_HS_CFG = 4'h7,
    DRE_FS_DEV = 4'h8, DRE_FS_CFG = 4'h9
  } dre_slot_t;
endpackage

//--- hw/dre_desc_ram.sv
// Purpose: Descriptor memory, one write port and one registered read port
// Assumes: Word wide; the reader issues an address and sees data one edge later
// Notes:   Contents are never cleared, so they survive any reset
module dre_desc_ram
  import dre_pkg::*;
(
  input  wire logic              i_ref_clk,
  input  wire logic              i_wr_en,
  input  wire logic [RAM_AW-1:0] i_wr_addr,
  input  wire logic [31:0]       i_wr_data,
  input  wire logic [RAM_AW-1:0] i_rd_addr,
  output logic      [31:0]       o_rd_data
);
  logic [31:0] mem_q [RAM_WORDS];

  always_ff @(posedge i_ref_clk) begin
    if (i_wr_en) begin
      mem_q[i_wr_addr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    o_rd_data <= mem_q[i_rd_addr];
  end
endmodule

//--- hw/dre_emulator.sv
// Purpose: Serves USB descriptors from RAM or from EEPROM-loaded data
// Assumes: i_rst is power-on reset; i_soft_rst is any other reset, one cycle
// Notes:   Descriptor bytes answer two edges after the request
//
// The implementer's own choices: the address map and the plain strobed port.
module dre_emulator
  import dre_pkg::*;
(
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst,
  input  wire logic                i_soft_rst,
  input  wire logic [7:0]          i_addr,
  input  wire logic [31:0]         i_wr_data,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  output logic      [31:0]         o_rd_data,
  input  wire logic                i_eep_present,
  input  wire logic                i_desc_req,
  input  wire logic [3:0]          i_desc_slot,
  input  wire logic [7:0]          i_desc_idx,
  input  wire logic [7:0]          i_eep_base,
  input  wire logic [7:0]          i_eep_len,
  input  wire logic [7:0]          i_eep_data,
  output logic      [7:0]          o_eep_addr,
  output logic                     o_desc_valid,
  output logic      [7:0]          o_desc_byte,
  output logic      [7:0]          o_desc_len,
  output logic      [47:0]         o_station_id,
  output logic      [1:0]          o_drive_gain,
  output logic                     o_indicator_choice,
  output logic      [NUM_PINS-1:0] o_pin_wake,
  output logic                     o_power_source_flag,
  output logic                     o_remote_wakeup_flag,
  output logic      [NUM_PINS-1:0] o_pme_flags,
  output logic                     o_emulation_active
);
  logic [31:0] hw_q, id_lo_q, id_hi_q, ind_q, wake_q;
  logic [31:0] hs_q, fs_q, txt0_q, txt1_q, flags_q;
  logic [RAM_AW-1:0] dp_addr_q;
  logic        attr_written_q;
  logic        emu, prot, test_mode, soft_clr, lang_ok;
  logic [7:0]  lens [NUM_DESC];
  logic [9:0]  base [NUM_DESC];
  logic        dp_wr;
  logic [RAM_AW-1:0] ram_rd_addr;
  logic [31:0] ram_rd_data;
  logic        s1_valid_q, s1_emu_q, s1_in_q, s1_eep_free_q;
  logic [3:0]  s1_slot_q;
  logic [7:0]  s1_idx_q, s1_len_q;
  logic [1:0]  s1_lane_q;
  logic [9:0]  req_addr;

  function automatic logic [9:0] align_len(input logic [7:0] len);
    align_len = ({2'b00, len} + 10'h003) & 10'h3fc;
  endfunction

  function automatic logic is_dev(input logic [3:0] slot);
    is_dev = (slot == DRE_HS_DEV) || (slot == DRE_FS_DEV);
  endfunction

  function automatic logic is_cfg(input logic [3:0] slot);
    is_cfg = (slot == DRE_HS_CFG) || (slot == DRE_FS_CFG);
  endfunction

  assign emu       = hw_q[HW_EMU_BIT];
  assign prot      = hw_q[HW_PROT_BIT];
  assign test_mode = hw_q[HW_TEST_BIT];
  // Unprotected soft reset behaves like power-on for the held state
  assign soft_clr  = i_soft_rst && !prot;
  assign lang_ok   = (txt0_q[31:8] != 24'h0) || (txt1_q[15:0] != 16'h0);
  assign dp_wr     = i_wr && (i_addr == OFS_DP_DATA) && test_mode;

  always_comb begin
    lens[DRE_LANG]   = txt0_q[7:0];
    lens[DRE_STR1]   = txt0_q[15:8];
    lens[DRE_STR2]   = txt0_q[23:16];
    lens[DRE_STR3]   = txt0_q[31:24];
    lens[DRE_STR4]   = txt1_q[7:0];
    lens[DRE_STR5]   = txt1_q[15:8];
    lens[DRE_HS_DEV] = hs_q[7:0];
    lens[DRE_HS_CFG] = hs_q[15:8];
    lens[DRE_FS_DEV] = fs_q[7:0];
    lens[DRE_FS_CFG] = fs_q[15:8];
  end

  assign base[0] = 10'h000;
  genvar g;
  generate
    for (g = 1; g < NUM_DESC; g++) begin : g_base
      assign base[g] = base[g-1] + align_len(lens[g-1]);
    end
  endgenerate

  assign req_addr = base[i_desc_slot] + {2'b00, i_desc_idx};
  assign ram_rd_addr = req_addr[RAM_AW+1:2];

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      hw_q    <= RST_WORD;
      id_lo_q <= RST_WORD;
      id_hi_q <= RST_WORD;
      ind_q   <= RST_WORD;
      wake_q  <= RST_WORD;
    end else if (soft_clr) begin
      hw_q    <= RST_WORD;
      id_lo_q <= RST_WORD;
      id_hi_q <= RST_WORD;
      ind_q   <= RST_WORD;
      wake_q  <= RST_WORD;
    end else if (i_wr) begin
      case (i_addr)
        OFS_HW_SETUP:  hw_q    <= i_wr_data;
        OFS_ID_LOWER:  id_lo_q <= i_wr_data;
        OFS_ID_UPPER:  id_hi_q <= {16'h0000, i_wr_data[15:0]};
        OFS_IND_SETUP: ind_q   <= {31'h0, i_wr_data[0]};
        OFS_PIN_WAKE:  wake_q  <= {21'h0, i_wr_data[NUM_PINS-1:0]};
        default:       hw_q    <= hw_q;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      hs_q <= RST_WORD;
      fs_q <= RST_WORD;
      txt0_q <= RST_WORD;
      txt1_q <= RST_WORD;
      attr_written_q <= 1'b0;
    end else if (soft_clr) begin
      hs_q <= RST_WORD;
      fs_q <= RST_WORD;
      txt0_q <= RST_WORD;
      txt1_q <= RST_WORD;
      attr_written_q <= 1'b0;
    end else if (i_wr) begin
      case (i_addr)
        OFS_HS_LEN: begin
          hs_q <= {16'h0, i_wr_data[15:0]};
          attr_written_q <= 1'b1;
        end
        OFS_FS_LEN: begin
          fs_q <= {16'h0, i_wr_data[15:0]};
          attr_written_q <= 1'b1;
        end
        OFS_TEXT0: begin
          txt0_q <= i_wr_data;
          attr_written_q <= 1'b1;
        end
        OFS_TEXT1: begin
          txt1_q <= {16'h0, i_wr_data[15:0]};
          attr_written_q <= 1'b1;
        end
        default: attr_written_q <= attr_written_q;
      endcase
    end
  end

  // Flag register; RAM config writes may patch it once lengths are known
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      flags_q <= RST_WORD;
    end else if (soft_clr) begin
      flags_q <= RST_WORD;
    end else if (dp_wr && attr_written_q &&
                 ((dp_addr_q == 7'((base[DRE_HS_CFG] + BMA_OFFSET) >> 2) &&
                   lens[DRE_HS_CFG] != 8'h00) ||
                  (dp_addr_q == 7'((base[DRE_FS_CFG] + BMA_OFFSET) >> 2) &&
                   lens[DRE_FS_CFG] != 8'h00))) begin
      flags_q[FLG_PWR_BIT] <= i_wr_data[24 + BMA_PWR_BIT];
      flags_q[FLG_RWK_BIT] <= i_wr_data[24 + BMA_RWK_BIT];
    end else if (i_wr && (i_addr == OFS_FLAGS) && !i_eep_present) begin
      flags_q <= {19'h0, i_wr_data[FLG_PME_LSB+NUM_PINS-1:0]};
    end
  end

  // Data port pointer steps one word per write
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      dp_addr_q <= '0;
    end else if (soft_clr) begin
      dp_addr_q <= '0;
    end else if (i_wr && (i_addr == OFS_DP_ADDR)) begin
      dp_addr_q <= i_wr_data[RAM_AW-1:0];
    end else if (dp_wr) begin
      dp_addr_q <= dp_addr_q + 7'h01;
    end
  end

  dre_desc_ram u_ram (
    .i_ref_clk (i_ref_clk),
    .i_wr_en   (dp_wr),
    .i_wr_addr (dp_addr_q),
    .i_wr_data (i_wr_data),
    .i_rd_addr (ram_rd_addr),
    .o_rd_data (ram_rd_data)
  );

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data <= RST_WORD;
    end else if (i_rd) begin
      case (i_addr)
        OFS_HW_SETUP:  o_rd_data <= hw_q;
        OFS_ID_LOWER:  o_rd_data <= id_lo_q;
        OFS_ID_UPPER:  o_rd_data <= id_hi_q;
        OFS_IND_SETUP: o_rd_data <= ind_q;
        OFS_PIN_WAKE:  o_rd_data <= wake_q;
        OFS_HS_LEN:    o_rd_data <= hs_q;
        OFS_FS_LEN:    o_rd_data <= fs_q;
        OFS_TEXT0:     o_rd_data <= txt0_q;
        OFS_TEXT1:     o_rd_data <= txt1_q;
        OFS_FLAGS:     o_rd_data <= i_eep_present ? RST_WORD : flags_q;
        OFS_DP_ADDR:   o_rd_data <= {25'h0, dp_addr_q};
        OFS_STATUS:    o_rd_data <= {29'h0, attr_written_q, lang_ok, emu};
        default:       o_rd_data <= RST_WORD;
      endcase
    end else begin
      o_rd_data <= RST_WORD;
    end
  end

  // Request stage: RAM or EEPROM address goes out, length is resolved
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_valid_q    <= 1'b0;
      s1_emu_q      <= 1'b0;
      s1_in_q       <= 1'b0;
      s1_eep_free_q <= 1'b0;
      s1_slot_q     <= 4'h0;
      s1_idx_q      <= 8'h00;
      s1_len_q      <= 8'h00;
      s1_lane_q     <= 2'h0;
      o_eep_addr    <= 8'h00;
    end else begin
      s1_valid_q <= i_desc_req;
      if (i_desc_req) begin
        s1_emu_q  <= emu;
        s1_slot_q <= i_desc_slot;
        s1_idx_q  <= i_desc_idx;
        s1_lane_q <= req_addr[1:0];
        if (emu) begin
          if (i_desc_slot == DRE_LANG && !lang_ok) begin
            s1_len_q <= 8'h00;
          end else if (is_dev(i_desc_slot) && lens[i_desc_slot] != 8'h00) begin
            s1_len_q <= DEV_SIZE;
          end else begin
            s1_len_q <= lens[i_desc_slot];
          end
          s1_in_q       <= (i_desc_idx < lens[i_desc_slot]);
          s1_eep_free_q <= 1'b0;
        end else begin
          s1_len_q      <= i_eep_len;
          s1_in_q       <= (i_desc_idx < i_eep_len);
          o_eep_addr    <= i_eep_base + i_desc_idx;
          s1_eep_free_q <= ((i_eep_base + i_desc_idx) >= EEP_FREE_LO);
        end
      end
    end
  end

  // Answer stage: byte patched as it leaves
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_desc_valid <= 1'b0;
      o_desc_byte  <= 8'h00;
      o_desc_len   <= 8'h00;
    end else begin
      o_desc_valid <= s1_valid_q;
      if (s1_valid_q) begin
        o_desc_len <= s1_len_q;
        if (!s1_in_q) begin
          o_desc_byte <= 8'h00;
        end else if (!s1_emu_q) begin
          o_desc_byte <= s1_eep_free_q ? 8'h00 : i_eep_data;
        end else if (is_dev(s1_slot_q) && s1_idx_q == 8'h00) begin
          o_desc_byte <= DEV_SIZE;
        end else if (is_dev(s1_slot_q) && s1_idx_q == 8'h01) begin
          o_desc_byte <= DEV_TYPE;
        end else if (is_cfg(s1_slot_q) && s1_idx_q == 8'h01) begin
          o_desc_byte <= CFG_TYPE;
        end else begin
          o_desc_byte <= ram_rd_data[8*s1_lane_q +: 8];
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_station_id         <= 48'h0;
      o_drive_gain         <= 2'h0;
      o_indicator_choice   <= 1'b0;
      o_pin_wake           <= '0;
      o_power_source_flag  <= 1'b0;
      o_remote_wakeup_flag <= 1'b0;
      o_pme_flags          <= '0;
      o_emulation_active   <= 1'b0;
    end else begin
      o_station_id         <= {id_hi_q[15:0], id_lo_q};
      o_drive_gain         <= hw_q[HW_GAIN_LSB +: 2];
      o_indicator_choice   <= ind_q[0];
      o_pin_wake           <= wake_q[NUM_PINS-1:0];
      o_power_source_flag  <= flags_q[FLG_PWR_BIT];
      o_remote_wakeup_flag <= flags_q[FLG_RWK_BIT];
      o_pme_flags          <= flags_q[FLG_PME_LSB +: NUM_PINS];
      o_emulation_active   <= emu;
    end
  end

  property p_lat;
    @(posedge i_ref_clk) disable iff (i_rst) i_desc_req |-> ##2 o_desc_valid;
  endproperty
  answer_latency_a: assert property (p_lat) else $error("answer not two edges");

  dev_size_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_desc_req && emu && is_dev(i_desc_slot) && i_desc_idx == 8'h00 &&
    lens[i_desc_slot] != 8'h00 |-> ##2 o_desc_byte == 8'h12)
    else $error("device size byte not forced");

  dev_type_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_desc_req && emu && is_dev(i_desc_slot) && i_desc_idx == 8'h01 &&
    lens[i_desc_slot] > 8'h01 |-> ##2 o_desc_byte == 8'h01)
    else $error("device type byte not forced");

  cfg_type_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_desc_req && emu && is_cfg(i_desc_slot) && i_desc_idx == 8'h01 &&
    lens[i_desc_slot] > 8'h01 |-> ##2 o_desc_byte == 8'h02)
    else $error("config type byte not forced");

  lang_off_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_desc_req && emu && i_desc_slot == DRE_LANG && !lang_ok |-> ##2 o_desc_len == 8'h00)
    else $error("language id served with no strings");

  flag_lock_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_wr && i_addr == OFS_FLAGS && i_eep_present && !i_soft_rst |=> $stable(flags_q))
    else $error("flag register changed under EEPROM");

  protect_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_soft_rst && prot && !i_wr |=> $stable(id_lo_q) && $stable(txt0_q) && $stable(hw_q))
    else $error("protected state lost on soft reset");

  eep_free_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_desc_req && !emu && (i_eep_base + i_desc_idx) >= EEP_FREE_LO |-> ##2 o_desc_byte == 8'h00)
    else $error("free EEPROM area served");

  port_step_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    dp_wr && !i_soft_rst |=> dp_addr_q == $past(dp_addr_q) + 7'h01)
    else $error("data port pointer did not step");

  cov_emu_dev_c: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    i_desc_req && emu && is_dev(i_desc_slot) ##2 o_desc_valid);
  cov_eep_c: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    i_desc_req && !emu ##2 o_desc_valid);
  cov_protect_c: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    i_soft_rst && prot && emu);
endmodule

//--- bench/dre_testbench.sv
// Purpose: Self-checking bench for the descriptor RAM emulation block
// Assumes: One 40 MHz clock; every input but i_eep_data is driven by NBA right after a rising edge
// Notes:   RAM layout follows the lengths in the register rows: lang 4, text 1 4,
//          HS device 18 at byte 8, HS config 18 at byte 28, full speed absent
module testbench
  import dre_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [7:0]  addr;
    logic [31:0] wdat;
    logic [31:0] rexp;
  } dre_reg_row_t;
  typedef struct {
    logic [3:0] slot;
    logic [7:0] idx;
    logic [7:0] byt;
    logic [7:0] len;
  } dre_desc_row_t;

  logic                i_ref_clk, i_rst, i_soft_rst, i_wr, i_rd, i_eep_present, i_desc_req;
  logic [7:0]          i_addr, i_desc_idx, i_eep_base, i_eep_len, i_eep_data;
  logic [31:0]         i_wr_data, o_rd_data;
  logic [3:0]          i_desc_slot;
  logic [7:0]          o_eep_addr, o_desc_byte, o_desc_len;
  logic                o_desc_valid, o_indicator_choice, o_power_source_flag;
  logic                o_remote_wakeup_flag, o_emulation_active;
  logic [47:0]         o_station_id;
  logic [1:0]          o_drive_gain;
  logic [NUM_PINS-1:0] o_pin_wake, o_pme_flags;
  int                  err_total, compares, cycles;

  // Flags row sets wakeup and all PME bits, not power; the patched bmAttributes byte later flips it to power
  // HS config length programmed as 18, never anything else
  dre_reg_row_t regs [12] = '{
    '{OFS_ID_LOWER,  32'h89ab_cdef, 32'h89ab_cdef}, '{OFS_ID_UPPER, 32'h0000_1234, 32'h0000_1234},
    '{OFS_IND_SETUP, 32'h0000_0001, 32'h0000_0001}, '{OFS_PIN_WAKE, 32'h0000_07ff, 32'h0000_07ff},
    '{OFS_HS_LEN,    32'h0000_1212, 32'h0000_1212}, '{OFS_FS_LEN,   32'h0000_0000, 32'h0000_0000},
    '{OFS_TEXT0,     32'h0000_0404, 32'h0000_0404}, '{OFS_TEXT1,    32'h0000_0000, 32'h0000_0000},
    '{OFS_FLAGS,     32'h0000_1ffe, 32'h0000_1ffe}, '{8'h3c,        32'hdead_beef, 32'h0000_0000},
    '{OFS_DP_ADDR,   32'h0000_0000, 32'h0000_0000}, '{OFS_HW_SETUP, 32'h0000_0034, 32'h0000_0034}
  };
  dre_desc_row_t descs [15] = '{
    '{DRE_LANG, 8'h00, 8'h00, 8'h04},   '{DRE_LANG, 8'h03, 8'h03, 8'h04},
    '{DRE_STR1, 8'h00, 8'h04, 8'h04},   '{DRE_STR2, 8'h00, 8'h00, 8'h00},
    '{DRE_HS_DEV, 8'h00, 8'h12, 8'h12}, '{DRE_HS_DEV, 8'h01, 8'h01, 8'h12},
    '{DRE_HS_DEV, 8'h03, 8'h02, 8'h12}, '{DRE_HS_DEV, 8'h11, 8'h01, 8'h12},
    '{DRE_HS_DEV, 8'h12, 8'h00, 8'h12}, '{DRE_HS_CFG, 8'h00, 8'h1c, 8'h12},
    '{DRE_HS_CFG, 8'h01, 8'h02, 8'h12}, '{DRE_HS_CFG, 8'h07, 8'h40, 8'h12},
    '{DRE_HS_CFG, 8'h08, 8'h24, 8'h12}, '{DRE_HS_CFG, 8'h12, 8'h00, 8'h12},
    '{DRE_FS_DEV, 8'h00, 8'h00, 8'h00}
  };

  // EEPROM stand-in: every byte differs from its address so a wrong pointer shows
  assign i_eep_data = ~o_eep_addr;

  dre_emulator u_dre_emulator (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_soft_rst(i_soft_rst), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
    .i_eep_present(i_eep_present), .i_desc_req(i_desc_req), .i_desc_slot(i_desc_slot),
    .i_desc_idx(i_desc_idx), .i_eep_base(i_eep_base), .i_eep_len(i_eep_len),
    .i_eep_data(i_eep_data), .o_eep_addr(o_eep_addr), .o_desc_valid(o_desc_valid),
    .o_desc_byte(o_desc_byte), .o_desc_len(o_desc_len), .o_station_id(o_station_id),
    .o_drive_gain(o_drive_gain), .o_indicator_choice(o_indicator_choice),
    .o_pin_wake(o_pin_wake), .o_power_source_flag(o_power_source_flag),
    .o_remote_wakeup_flag(o_remote_wakeup_flag), .o_pme_flags(o_pme_flags),
    .o_emulation_active(o_emulation_active)
  );

  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Run is under two hundred cycles; the ceiling only catches a hang
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      err_total++;
      conclude();
    end
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr      <= 1'b1;
    i_addr    <= a;
    i_wr_data <= d;
    @(posedge i_ref_clk);
    i_wr      <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_ref_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd   <= 1'b0;
    #1;
    chk(o_rd_data, e, "register read");
  endtask

  task automatic req(input logic [3:0] s, input logic [7:0] ix, input logic [7:0] b,
                     input logic [7:0] l, input logic [7:0] eb, input logic [7:0] el);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    i_desc_req  <= 1'b1;
    i_desc_slot <= s;
    i_desc_idx  <= ix;
    i_eep_base  <= b;
    i_eep_len   <= l;
    @(posedge i_ref_clk);
    i_desc_req  <= 1'b0;
    do begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end while (o_desc_valid !== 1'b1 && n < 4);
    chk(n, 1, "answer latency");
    chk(o_desc_valid, 1'b1, "descriptor valid");
    chk(o_desc_byte, eb, "descriptor byte");
    chk(o_desc_len, el, "descriptor length");
  endtask

  task automatic soft_pulse();
    @(posedge i_ref_clk);
    i_soft_rst <= 1'b1;
    @(posedge i_ref_clk);
    i_soft_rst <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    #1;
  endtask

  // Byte b of RAM holds b, except the HS device fields below and the HS config string index and attribute byte (bus power bit set)
  function automatic logic [31:0] ram_word(input int k);
    logic [31:0] w;
    for (int j = 0; j < 4; j++) begin
      w[8*j +: 8] = 8'(4 * k + j);
    end
    // bcdUSB 0200h, packet size 40h, one configuration
    if (k == 2) w[31:16] = 16'h0200;
    if (k == 3) w[31:24] = 8'h40;
    // Absent strings are referred to by index zero
    if (k == 5) w[31:16] = 16'h0001;
    if (k == 6) w[15:0] = 16'h0100;
    if (k == 8) w[31:16] = 16'h4000;
    return w;
  endfunction

  initial begin
    {i_rst, i_soft_rst, i_wr, i_rd, i_eep_present, i_desc_req} = 6'h20;
    {i_addr, i_desc_idx, i_eep_base, i_eep_len, i_desc_slot} = 36'h0;
    i_wr_data = 32'h0;
    repeat (4) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    rd(OFS_HW_SETUP, RST_WORD);
    chk(o_station_id, 48'h0, "id after reset");
    for (int i = 0; i < 12; i++) begin
      wr(regs[i].addr, regs[i].wdat);
      rd(regs[i].addr, regs[i].rexp);
    end
    chk(o_station_id, 48'h1234_89ab_cdef, "station id");
    chk({o_drive_gain, o_indicator_choice, o_pin_wake, o_pme_flags},
        {2'h3, 1'h1, 11'h7ff, 11'h7ff}, "preset outputs");
    for (int k = 0; k < 12; k++) begin
      wr(OFS_DP_DATA, ram_word(k));
    end
    rd(OFS_FLAGS, 32'h0000_1ffd);
    chk({o_power_source_flag, o_remote_wakeup_flag}, 2'b10, "patched flags");
    wr(OFS_HW_SETUP, 32'h0000_0037);
    wr(OFS_HW_SETUP, 32'h0000_0033);
    wr(OFS_DP_ADDR, 32'h0000_0000);
    wr(OFS_DP_DATA, 32'hffff_ffff);
    chk(o_emulation_active, 1'b1, "emulation on");
    for (int i = 0; i < 15; i++) begin
      req(descs[i].slot, descs[i].idx, 8'h00, 8'h00, descs[i].byt, descs[i].len);
    end
    wr(OFS_TEXT0, 32'h0000_0004);
    req(DRE_LANG, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    wr(OFS_TEXT0, 32'h0000_0404);
    soft_pulse();
    rd(OFS_HW_SETUP, 32'h0000_0033);
    rd(OFS_TEXT0, 32'h0000_0404);
    chk(o_station_id, 48'h1234_89ab_cdef, "protected id");
    req(DRE_HS_CFG, 8'h00, 8'h00, 8'h00, 8'h1c, 8'h12);
    wr(OFS_HW_SETUP, 32'h0000_0000);
    req(DRE_HS_DEV, 8'h02, 8'h50, 8'h12, 8'had, 8'h12);
    req(DRE_HS_CFG, 8'h05, 8'h90, 8'h09, 8'h6a, 8'h09);
    req(DRE_HS_CFG, 8'h06, 8'h90, 8'h09, 8'h00, 8'h09);
    @(posedge i_ref_clk);
    i_eep_present <= 1'b1;
    wr(OFS_FLAGS, 32'h0000_0003);
    rd(OFS_FLAGS, 32'h0000_0000);
    @(posedge i_ref_clk);
    i_eep_present <= 1'b0;
    rd(OFS_FLAGS, 32'h0000_1ffd);
    soft_pulse();
    rd(OFS_ID_LOWER, 32'h0000_0000);
    chk(o_station_id, 48'h0, "unprotected id");
    conclude();
  end
endmodule
